// >>> jtag_tap_pkg.sv
// Constants shared by the boundary-scan test access port.
package jtag_tap_pkg;

    // ------------------------------------------------------------
    // Instruction register
    // ------------------------------------------------------------
    localparam int IR_WIDTH = 5;
    localparam logic [4:0] OP_EXTEST     = 5'h00;
    localparam logic [4:0] OP_SAMPLE     = 5'h01;
    localparam logic [4:0] OP_INT_SCAN   = 5'h02;
    localparam logic [4:0] OP_CLAMP      = 5'h04;
    localparam logic [4:0] OP_HIGHZ      = 5'h05;
    localparam logic [4:0] OP_PHY_PRIV   = 5'h09;
    localparam logic [4:0] OP_MEM_SELF   = 5'h0A;
    localparam logic [4:0] OP_IDCODE     = 5'h0C;
    localparam logic [4:0] OP_BYPASS     = 5'h1F;
    // Fixed capture pattern of the instruction register, low bits 01.
    localparam logic [4:0] IR_CAPTURE    = 5'h01;

    // ------------------------------------------------------------
    // Identification register layout
    // ------------------------------------------------------------
    localparam int ID_WIDTH     = 32;
    localparam int ID_VER_LSB   = 28;
    localparam int ID_PART_LSB  = 12;
    localparam int ID_MFR_LSB   = 1;
    localparam logic ID_FIXED_BIT = 1'b1;

    // ------------------------------------------------------------
    // Controller states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_RESET    = 4'h0, ST_IDLE     = 4'h1, ST_SEL_DR  = 4'h2, ST_CAP_DR  = 4'h3,
        ST_SHIFT_DR = 4'h4, ST_EXIT1_DR = 4'h5, ST_PAUSE_DR = 4'h6, ST_EXIT2_DR = 4'h7,
        ST_UPD_DR   = 4'h8, ST_SEL_IR   = 4'h9, ST_CAP_IR  = 4'hA, ST_SHIFT_IR = 4'hB,
        ST_EXIT1_IR = 4'hC, ST_PAUSE_IR = 4'hD, ST_EXIT2_IR = 4'hE, ST_UPD_IR  = 4'hF
    } tap_state_e;

endpackage : jtag_tap_pkg

// >>> jtag_tap_boundary_scan.sv
// Test access port controller, instruction decode and scan data registers.
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - Five test pins: clock, data in, data out, mode select, active-low reset.
// - Sixteen-state controller advances on test clock rises following mode select.
// - Own power-on reset forces the controller into Test-Logic-Reset.
// - Five-bit instruction register selects the data register in the scan path.
// - Undefined instruction codes behave exactly like the all-ones bypass.
// - Code 00000 selects boundary chain, pins driven from chain.
// - Code 00001 selects boundary chain, captures pins, normal operation kept.
// - Code 00101 uses bypass and floats all outputs except data out.
// - Code 00100 drives pins from boundary cells, bypass in path.
// - Code 01100 selects the identification register.
// - Code 11111 puts only the bypass stage in the path.
// - Bypass register is a single shift stage.
// - Identification holds version 31-28, part 27-12, maker 11-1, read-only.
// - Identification bit zero is always one.
// - Every functional pin is covered by a boundary cell.
// - Boundary chain shifts from data in toward data out.
// - Sample and external test load cells in parallel on test clock rise.
module jtag_tap_boundary_scan #(
    parameter int          BSR_LEN = 54,
    parameter logic [3:0]  ID_VER  = 4'h0,     // Arbitrary value.
    parameter logic [15:0] ID_PART = 16'h0000, // Arbitrary value.
    parameter logic [10:0] ID_MFR  = 11'h000   // Arbitrary value.
) (
    input  wire logic               clock,
    input  wire logic               resetn,
    input  wire logic               powerOnResetn,
    input  wire logic               tck,
    input  wire logic               tdi,
    input  wire logic               tms,
    input  wire logic               trstn,
    output logic                    tdo,
    output logic                    tdoEn,
    input  wire logic [BSR_LEN-1:0] pinIn,
    input  wire logic [BSR_LEN-1:0] coreOut,
    output logic      [BSR_LEN-1:0] pinOut,
    output logic                    pinHighZ,
    output logic      [3:0]         tapState
);
    if (BSR_LEN < 2) begin : g_len_check
        $error("BSR_LEN must be at least 2.");
    end

    // ------------------------------------------------------------
    // Reset and input synchronisers
    // ------------------------------------------------------------
    logic [1:0] rstSync_r;
    logic       rstn;
    logic [1:0] tckSync_r, tdiSync_r, tmsSync_r, trstSync_r, porSync_r;
    logic       tckPrev_r;
    logic [BSR_LEN-1:0] pinMeta_r, pinSync_r;

    // Reset released through two stages.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) rstSync_r <= 2'h0;
        else rstSync_r <= {rstSync_r[0], 1'b1};
    end
    assign rstn = rstSync_r[1];

    // Tester pins and device pins cross into the local clock; only the second
    // stage is read, so a metastable first stage never reaches the logic.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            tckSync_r  <= 2'h0;
            tdiSync_r  <= 2'h0;
            tmsSync_r  <= 2'h3;
            trstSync_r <= 2'h0;
            porSync_r  <= 2'h0;
            tckPrev_r  <= 1'b0;
            pinMeta_r  <= '0;
            pinSync_r  <= '0;
        end else begin
            tckSync_r  <= {tckSync_r[0], tck};
            tdiSync_r  <= {tdiSync_r[0], tdi};
            tmsSync_r  <= {tmsSync_r[0], tms};
            trstSync_r <= {trstSync_r[0], trstn};
            porSync_r  <= {porSync_r[0], powerOnResetn};
            tckPrev_r  <= tckSync_r[1];
            pinMeta_r  <= pinIn;
            pinSync_r  <= pinMeta_r;
        end
    end

    // Edge detection on the sampled test clock.
    wire tckRise  = tckSync_r[1] & ~tckPrev_r;
    wire tckFall  = ~tckSync_r[1] & tckPrev_r;
    wire tdiS     = tdiSync_r[1];
    wire tmsS     = tmsSync_r[1];
    // Either test reset or the private power-on reset holds the controller.
    wire testRst  = ~trstSync_r[1] | ~porSync_r[1];

    // ------------------------------------------------------------
    // Controller state machine
    // ------------------------------------------------------------
    jtag_tap_pkg::tap_state_e state_r, state_nxt;

    // Standard transitions steered by mode select.
    always_comb begin
        case (state_r)
            jtag_tap_pkg::ST_RESET:    state_nxt = tmsS ? jtag_tap_pkg::ST_RESET    : jtag_tap_pkg::ST_IDLE;
            jtag_tap_pkg::ST_IDLE:     state_nxt = tmsS ? jtag_tap_pkg::ST_SEL_DR   : jtag_tap_pkg::ST_IDLE;
            jtag_tap_pkg::ST_SEL_DR:   state_nxt = tmsS ? jtag_tap_pkg::ST_SEL_IR   : jtag_tap_pkg::ST_CAP_DR;
            jtag_tap_pkg::ST_CAP_DR:   state_nxt = tmsS ? jtag_tap_pkg::ST_EXIT1_DR : jtag_tap_pkg::ST_SHIFT_DR;
            jtag_tap_pkg::ST_SHIFT_DR: state_nxt = tmsS ? jtag_tap_pkg::ST_EXIT1_DR : jtag_tap_pkg::ST_SHIFT_DR;
            jtag_tap_pkg::ST_EXIT1_DR: state_nxt = tmsS ? jtag_tap_pkg::ST_UPD_DR   : jtag_tap_pkg::ST_PAUSE_DR;
            jtag_tap_pkg::ST_PAUSE_DR: state_nxt = tmsS ? jtag_tap_pkg::ST_EXIT2_DR : jtag_tap_pkg::ST_PAUSE_DR;
            jtag_tap_pkg::ST_EXIT2_DR: state_nxt = tmsS ? jtag_tap_pkg::ST_UPD_DR   : jtag_tap_pkg::ST_SHIFT_DR;
            jtag_tap_pkg::ST_UPD_DR:   state_nxt = tmsS ? jtag_tap_pkg::ST_SEL_DR   : jtag_tap_pkg::ST_IDLE;
            jtag_tap_pkg::ST_SEL_IR:   state_nxt = tmsS ? jtag_tap_pkg::ST_RESET    : jtag_tap_pkg::ST_CAP_IR;
            jtag_tap_pkg::ST_CAP_IR:   state_nxt = tmsS ? jtag_tap_pkg::ST_EXIT1_IR : jtag_tap_pkg::ST_SHIFT_IR;
            jtag_tap_pkg::ST_SHIFT_IR: state_nxt = tmsS ? jtag_tap_pkg::ST_EXIT1_IR : jtag_tap_pkg::ST_SHIFT_IR;
            jtag_tap_pkg::ST_EXIT1_IR: state_nxt = tmsS ? jtag_tap_pkg::ST_UPD_IR   : jtag_tap_pkg::ST_PAUSE_IR;
            jtag_tap_pkg::ST_PAUSE_IR: state_nxt = tmsS ? jtag_tap_pkg::ST_EXIT2_IR : jtag_tap_pkg::ST_PAUSE_IR;
            jtag_tap_pkg::ST_EXIT2_IR: state_nxt = tmsS ? jtag_tap_pkg::ST_UPD_IR   : jtag_tap_pkg::ST_SHIFT_IR;
            jtag_tap_pkg::ST_UPD_IR:   state_nxt = tmsS ? jtag_tap_pkg::ST_SEL_DR   : jtag_tap_pkg::ST_IDLE;
            default:                   state_nxt = jtag_tap_pkg::ST_RESET;
        endcase
    end

    // State advances only on a test clock rise.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) state_r <= jtag_tap_pkg::ST_RESET;
        else if (testRst) state_r <= jtag_tap_pkg::ST_RESET;
        else if (tckRise) state_r <= state_nxt;
    end
    assign tapState = state_r;

    wire inReset  = (state_r == jtag_tap_pkg::ST_RESET);
    wire capDr    = (state_r == jtag_tap_pkg::ST_CAP_DR)   & tckRise;
    wire shDr     = (state_r == jtag_tap_pkg::ST_SHIFT_DR) & tckRise;
    wire updDr    = (state_r == jtag_tap_pkg::ST_UPD_DR)   & tckFall;
    wire capIr    = (state_r == jtag_tap_pkg::ST_CAP_IR)   & tckRise;
    wire shIr     = (state_r == jtag_tap_pkg::ST_SHIFT_IR) & tckRise;
    wire updIr    = (state_r == jtag_tap_pkg::ST_UPD_IR)   & tckFall;

    // ------------------------------------------------------------
    // Instruction register and decode
    // ------------------------------------------------------------
    logic [jtag_tap_pkg::IR_WIDTH-1:0] irShift_r, ir_r;

    // Shift stage and held instruction; reset chooses identification.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            irShift_r <= jtag_tap_pkg::IR_CAPTURE;
            ir_r      <= jtag_tap_pkg::OP_IDCODE;
        end else if (testRst || inReset) begin
            irShift_r <= jtag_tap_pkg::IR_CAPTURE;
            ir_r      <= jtag_tap_pkg::OP_IDCODE;
        end else begin
            if (capIr) irShift_r <= jtag_tap_pkg::IR_CAPTURE;
            else if (shIr) irShift_r <= {tdiS, irShift_r[jtag_tap_pkg::IR_WIDTH-1:1]};
            if (updIr) ir_r <= irShift_r;
        end
    end

    // Decode; anything unlisted falls through to the bypass path.
    wire selExtest = (ir_r == jtag_tap_pkg::OP_EXTEST);
    wire selSample = (ir_r == jtag_tap_pkg::OP_SAMPLE);
    wire selHighZ  = (ir_r == jtag_tap_pkg::OP_HIGHZ);
    wire selClamp  = (ir_r == jtag_tap_pkg::OP_CLAMP);
    wire selId     = (ir_r == jtag_tap_pkg::OP_IDCODE);
    wire selIntSc  = (ir_r == jtag_tap_pkg::OP_INT_SCAN);
    wire selPhy    = (ir_r == jtag_tap_pkg::OP_PHY_PRIV);
    wire selMem    = (ir_r == jtag_tap_pkg::OP_MEM_SELF);
    wire selBsr    = selExtest | selSample;
    wire selPriv   = selIntSc | selPhy | selMem;
    wire selBypass = ~(selBsr | selId | selPriv);

    // ------------------------------------------------------------
    // Data registers
    // ------------------------------------------------------------
    logic                                bypass_r;
    logic                                priv_r;
    logic [jtag_tap_pkg::ID_WIDTH-1:0]   idShift_r;
    logic [BSR_LEN-1:0]                  bsrShift_r, bsrHold_r;
    wire  [jtag_tap_pkg::ID_WIDTH-1:0]   idValue = {ID_VER, ID_PART, ID_MFR,
                                                    jtag_tap_pkg::ID_FIXED_BIT};

    // Capture loads, shift moves toward data out, update latches the chain.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            bypass_r   <= 1'b0;
            priv_r     <= 1'b0;
            idShift_r  <= '0;
            bsrShift_r <= '0;
            bsrHold_r  <= '0;
        end else begin
            if (capDr) begin
                bypass_r  <= 1'b0;
                priv_r    <= 1'b0;
                idShift_r <= idValue;
                if (selBsr) bsrShift_r <= pinSync_r;
            end else if (shDr) begin
                bypass_r   <= tdiS;
                priv_r     <= tdiS;
                idShift_r  <= {tdiS, idShift_r[jtag_tap_pkg::ID_WIDTH-1:1]};
                if (selBsr) bsrShift_r <= {tdiS, bsrShift_r[BSR_LEN-1:1]};
            end
            if (updDr && selBsr) bsrHold_r <= bsrShift_r;
        end
    end

    // Pins follow the chain under external test or clamp, the core otherwise.
    wire drivePins = selExtest | selClamp;
    wire [BSR_LEN-1:0] pinSel = drivePins ? bsrHold_r : coreOut;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pinOut   <= '0;
            pinHighZ <= 1'b0;
        end else begin
            pinOut   <= pinSel;
            pinHighZ <= selHighZ;
        end
    end

    // Serial output changes on the falling edge, enabled only while shifting.
    wire inShift = (state_r == jtag_tap_pkg::ST_SHIFT_DR) | (state_r == jtag_tap_pkg::ST_SHIFT_IR);
    wire drBit   = selBsr ? bsrShift_r[0] :
                   selId  ? idShift_r[0]  :
                   selPriv ? priv_r : bypass_r;
    wire outBit  = (state_r == jtag_tap_pkg::ST_SHIFT_IR) ? irShift_r[0] : drBit;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            tdo   <= 1'b0;
            tdoEn <= 1'b0;
        end else if (tckFall) begin
            tdo   <= outBit;
            tdoEn <= inShift;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_reset_state;
        @(posedge clock) disable iff (!rstn) testRst |=> inReset;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("Test reset ignored.");

    property p_step_on_rise;
        @(posedge clock) disable iff (!rstn) (!tckRise && !testRst) |=> $stable(state_r);
    endproperty
    a_step_on_rise: assert property (p_step_on_rise) else $error("State moved without clock.");

    property p_tms_reset;
        @(posedge clock) disable iff (!rstn)
            (tckRise && tmsS && state_r == jtag_tap_pkg::ST_SEL_IR) |=> inReset;
    endproperty
    a_tms_reset: assert property (p_tms_reset) else $error("Select-IR did not reset.");

    property p_id_default;
        @(posedge clock) disable iff (!rstn) inReset |=> selId;
    endproperty
    a_id_default: assert property (p_id_default) else $error("Reset instruction wrong.");

    property p_undef_bypass;
        @(posedge clock) disable iff (!rstn) (ir_r == 5'h03) |-> selBypass;
    endproperty
    a_undef_bypass: assert property (p_undef_bypass) else $error("Undefined code not bypass.");

    property p_bypass_shift;
        @(posedge clock) disable iff (!rstn) shDr |=> (bypass_r == $past(tdiS));
    endproperty
    a_bypass_shift: assert property (p_bypass_shift) else $error("Bypass stage wrong.");

    property p_id_capture;
        @(posedge clock) disable iff (!rstn) capDr |=> (idShift_r[0] == 1'b1);
    endproperty
    a_id_capture: assert property (p_id_capture) else $error("Identification bit 0 not one.");

    property p_highz;
        @(posedge clock) disable iff (!rstn) selHighZ |=> pinHighZ;
    endproperty
    a_highz: assert property (p_highz) else $error("High impedance not applied.");

    property p_clamp;
        @(posedge clock) disable iff (!rstn) (selClamp && $stable(bsrHold_r)) |=> (pinOut == bsrHold_r);
    endproperty
    a_clamp: assert property (p_clamp) else $error("Clamp does not drive from cells.");

    c_shift_dr: cover property (@(posedge clock) disable iff (!rstn) shDr && selId);
    c_update_ir: cover property (@(posedge clock) disable iff (!rstn) updIr);
    c_extest: cover property (@(posedge clock) disable iff (!rstn) capDr && selExtest);

endmodule : jtag_tap_boundary_scan

`default_nettype wire

// >>> jtag_host_model.sv
// Behavioural board tester that drives the test access port pins.
`timescale 1ns/10ps
`default_nettype none
module jtag_host_model #(
    parameter int HALF_NS = 80
) (
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    output logic      trstn,
    input  wire logic tdo
);
    // Extra low time per pulse for a slow tester; keep it a multiple of 10 ns
    // so that test clock edges never land on a system clock edge.
    int lowExtra = 0;

    // The clock stands still low between scans, as a real tester leaves it.
    initial begin
        tck   = 1'h0;
        tms   = 1'h1;
        tdi   = 1'h0;
        trstn = 1'h1;
    end

    // One pulse: mode and data change while the clock is low and hold
    // through the rise, where data out is taken.
    task automatic tick(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #(HALF_NS + 1 + lowExtra);
        tck = 1'h1;
        o = tdo;
        #(HALF_NS - 1);
        tck = 1'h0;
    endtask : tick

    // Level of the active-low test reset pin.
    task automatic drive_trst(input logic v);
        trstn = v;
    endtask : drive_trst

    // From Run-Test/Idle through one data or instruction scan and back to
    // Run-Test/Idle, shifting n bits with the least significant first.
    task automatic scan(input logic ir, input int n, input logic [63:0] din,
                        output logic [63:0] dout);
        logic o;
        dout = '0;
        tick(1'h1, 1'h0, o);
        if (ir) tick(1'h1, 1'h0, o);
        tick(1'h0, 1'h0, o);
        tick(1'h0, 1'h0, o);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], o);
            dout[i] = o;
        end
        tick(1'h1, 1'h0, o);
        tick(1'h0, 1'h0, o);
    endtask : scan
endmodule : jtag_host_model
`default_nettype wire

// >>> tb.sv
// Self-checking testbench of the boundary-scan test access port.
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam int          BSR   = 54;
    localparam logic [3:0]  VER   = 4'h9;     // Arbitrary value.
    localparam logic [15:0] PART  = 16'hA5C3; // Arbitrary value.
    localparam logic [10:0] MFR   = 11'h2B6;  // Arbitrary value.
    localparam logic [31:0] IDVAL = {VER, PART, MFR, 1'h1};
    localparam logic [53:0] CORE  = 54'h1_2345_6789_ABCD;
    localparam logic [53:0] P1    = 54'h2_A5C3_F0E1_9B7D;
    localparam logic [53:0] P2    = 54'h1_5A3C_0F1E_6482;
    localparam logic [53:0] P3    = 54'h3_0C96_7E21_D45B;
    localparam logic [53:0] P4    = 54'h0_F00F_A55A_3CC3;

    logic           clock;
    logic           resetn;
    logic           powerOnResetn;
    logic           tck, tdi, tms, trstn, tdo, tdoEn, pinHighZ;
    logic [BSR-1:0] pinIn, coreOut, pinOut;
    logic [3:0]     tapState;
    int             err_count   = 0;
    int             check_count = 0;
    int             cycles      = 0;

    jtag_tap_boundary_scan #(.BSR_LEN(BSR), .ID_VER(VER), .ID_PART(PART), .ID_MFR(MFR)) dut (
        .clock(clock), .resetn(resetn), .powerOnResetn(powerOnResetn), .tck(tck),
        .tdi(tdi), .tms(tms), .trstn(trstn), .tdo(tdo), .tdoEn(tdoEn), .pinIn(pinIn),
        .coreOut(coreOut), .pinOut(pinOut), .pinHighZ(pinHighZ), .tapState(tapState));

    jtag_host_model host (.tck(tck), .tms(tms), .tdi(tdi), .trstn(trstn), .tdo(tdo));

    // ------------------------------------------------------------
    // Clock, watchdog and reporting
    // ------------------------------------------------------------
    initial begin
        clock = 1'h0;
        forever #5 clock = ~clock;
    end

    // The whole run needs about 21000 cycles; a hang stops well after that.
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            err_count++;
            end_of_test();
        end
    end

    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test

    // Waits n cycles and steps 3 ns off the edge so tester pins never race it.
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #3;
    endtask : settle

    // ------------------------------------------------------------
    // Shared scan helpers
    // ------------------------------------------------------------
    task automatic load_ir(input logic [4:0] op);
        logic [63:0] d;
        host.scan(1'h1, 5, {59'h0, op}, d);
        check("ir capture", 64'(d[4:0]), 64'(jtag_tap_pkg::IR_CAPTURE));
    endtask : load_ir

    // Reads the identification register from Test-Logic-Reset or Idle.
    task automatic id_read();
        logic [63:0] d;
        logic        o;
        host.tick(1'h0, 1'h0, o);
        host.scan(1'h0, 32, 64'h0, d);
        check("id", d, 64'(IDVAL));
        check("id fixed bit", 64'(d[0]), 64'h1);
    endtask : id_read

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Visits all sixteen states; data out is enabled only in the shift states.
    task automatic walk_states();
        logic [20:0] m = 21'h095E5F;
        logic [83:0] s = 84'h1234_5674_5829_ABCD_EF29_0;
        logic        o;
        for (int i = 0; i < 21; i++) begin
            host.tick(m[20 - i], 1'h0, o);
            settle(6);
            check("state", 64'(tapState), 64'(s[83 - 4 * i -: 4]));
            check("out enable", 64'(tdoEn), 64'(s[83 - 4 * i -: 4] inside {4'h4, 4'hB}));
        end
    endtask : walk_states

    // Slow tester first; a written pattern must not stick in the register.
    task automatic test_id();
        logic [63:0] d;
        host.lowExtra = 320;
        id_read();
        host.lowExtra = 0;
        host.scan(1'h0, 32, '1, d);
        id_read();
    endtask : test_id

    // Every defined code but identification, plus three undefined ones: path length and capture value.
    task automatic opcode_paths();
        logic [4:0]  ops [11] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05,
                                  5'h09, 5'h0A, 5'h0D, 5'h1E, 5'h1F};
        logic [63:0] d;
        logic [63:0] mask;
        int          len;
        mask = (64'h1 << (BSR + 1)) - 64'h1;
        for (int i = 0; i < 11; i++) begin
            len = (ops[i] <= 5'h01) ? BSR : 1;
            load_ir(ops[i]);
            host.scan(1'h0, BSR + 1, '1, d);
            check("path", d & mask, mask & ~((64'h1 << len) - 64'h1));
            check("high z", 64'(pinHighZ), 64'(ops[i] == 5'h05));
            if (ops[i] != 5'h00 && ops[i] != 5'h04) check("pins", 64'(pinOut), 64'(coreOut));
        end
    endtask : opcode_paths

    // Sample and preload, then drive from the chain, clamp and release.
    task automatic sample_extest();
        logic [63:0] d;
        @(posedge clock) pinIn <= P1;
        settle(2);
        load_ir(5'h01);
        host.scan(1'h0, BSR, 64'(P2), d);
        check("sampled pins", d, 64'(P1));
        check("pins under sample", 64'(pinOut), 64'(coreOut));
        load_ir(5'h00);
        check("preloaded pins", 64'(pinOut), 64'(P2));
        @(posedge clock) pinIn <= P3;
        settle(2);
        host.scan(1'h0, BSR, 64'(P4), d);
        check("extest capture", d, 64'(P3));
        check("driven pins", 64'(pinOut), 64'(P4));
        load_ir(5'h04);
        check("clamped pins", 64'(pinOut), 64'(P4));
        check("clamp not floating", 64'(pinHighZ), 64'h0);
        load_ir(5'h1F);
        check("released pins", 64'(pinOut), 64'(coreOut));
    endtask : sample_extest

    // Test reset pin, power-on reset and five mode-select ones each restore IDCODE.
    task automatic test_resets();
        logic o;
        load_ir(5'h1F);
        host.tick(1'h1, 1'h0, o);
        host.drive_trst(1'h0);
        settle(6);
        check("state on test reset", 64'(tapState), 64'h0);
        host.drive_trst(1'h1);
        settle(6);
        id_read();
        load_ir(5'h1F);
        @(posedge clock) powerOnResetn <= 1'h0;
        settle(6);
        check("state on power-on reset", 64'(tapState), 64'h0);
        @(posedge clock) powerOnResetn <= 1'h1;
        settle(6);
        id_read();
        load_ir(5'h1F);
        for (int i = 0; i < 5; i++) host.tick(1'h1, 1'h0, o);
        check("state after five ones", 64'(tapState), 64'h0);
        id_read();
    endtask : test_resets

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        resetn        = 1'h0;
        powerOnResetn = 1'h0;
        pinIn         = '0;
        coreOut       = CORE;
        repeat (2) @(posedge clock);
        resetn        <= 1'h1;
        powerOnResetn <= 1'h1;
        settle(6);
        check("state after power-up", 64'(tapState), 64'h0);
        walk_states();
        test_id();
        opcode_paths();
        sample_extest();
        test_resets();
        end_of_test();
    end
endmodule : tb
`default_nettype wire
